/* File: core/blcur_pkg.sv */
`default_nettype none
package blcur_pkg;
    // Register offsets on the device register file
    localparam logic [7:0] REG_OFFICE_MAX = 8'h0B;
    localparam logic [7:0] REG_OFFICE_DIM = 8'h0C;
    localparam logic [7:0] REG_DARK_MAX   = 8'h0D;
    localparam logic [7:0] REG_DARK_DIM   = 8'h0E;

    // Register indices within this slice
    localparam int         NUM_REGS       = 4;
    localparam logic [1:0] IDX_OFFICE_MAX = 2'h0;
    localparam logic [1:0] IDX_OFFICE_DIM = 2'h1;
    localparam logic [1:0] IDX_DARK_MAX   = 2'h2;
    localparam logic [1:0] IDX_DARK_DIM   = 2'h3;

    // Field layout: code in 6:0, bit 7 reserved
    localparam int         CODE_W     = 7;
    localparam int         CODE_MSB   = 6;
    localparam int         RSVD_BIT   = 7;
    localparam logic [6:0] RESET_CODE = 7'h00;
    localparam logic [6:0] CODE_TOP   = 7'h7F;

    // Transfer law encodings
    localparam logic [1:0] LAW_LINEAR  = 2'h0;
    localparam logic [1:0] LAW_SQUARE  = 2'h1;
    localparam logic [1:0] LAW_CUBIC10 = 2'h2;
    localparam logic [1:0] LAW_CUBIC11 = 2'h3;

    // Code to current arithmetic, microamps
    localparam int          CUR_W       = 15;
    localparam logic [29:0] MAP_FULL_UA = 30'h0000_7530;
    localparam logic [29:0] MAP_LIN_DIV = 30'h0000_007F;
    localparam logic [29:0] MAP_LIN_RND = 30'h0000_003F;
    localparam logic [29:0] MAP_SQ_DIV  = 30'h0000_3F01;
    localparam logic [29:0] MAP_SQ_RND  = 30'h0000_1F80;

    // Expected currents at checked codes, microamps
    localparam logic [14:0] UA_FULL  = 15'h7530;
    localparam logic [14:0] UA_LIN_1 = 15'h00EC;
    localparam logic [14:0] UA_SQ_1  = 15'h0002;
    localparam logic [14:0] UA_SQ_2  = 15'h0007;
    localparam logic [14:0] UA_SQ_3  = 15'h0011;
endpackage
`default_nettype wire

/* File: core/blcur_law_map.sv */
`timescale 1ns/100ps
`default_nettype none
module blcur_law_map (
    // Code and law
    input  wire logic [6:0]  i_code,
    input  wire logic [1:0]  i_law,
    // Sink current in microamps
    output logic      [14:0] o_current_ua
);
    logic [29:0] code_ext;
    logic [29:0] lin_ua;
    logic [29:0] sq_ua;

    // Rounded divides keep the low square codes near their table values
    always_comb begin
        code_ext = {23'h00_0000, i_code};
        lin_ua   = (blcur_pkg::MAP_FULL_UA * code_ext + blcur_pkg::MAP_LIN_RND)
                   / blcur_pkg::MAP_LIN_DIV;
        sq_ua    = (blcur_pkg::MAP_FULL_UA * code_ext * code_ext + blcur_pkg::MAP_SQ_RND)
                   / blcur_pkg::MAP_SQ_DIV;
        // (RULE2) Linear steps
        // (RULE6) Square law, (RULE9) cubic laws reuse it
        if (i_law == blcur_pkg::LAW_LINEAR) begin
            o_current_ua = lin_ua[14:0];
        end else begin
            o_current_ua = sq_ua[14:0];
        end
    end
endmodule
`default_nettype wire

/* File: core/blcur_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// (RULE1) Office maximum code register at 0x0B, code in bits 6:0, bit 7 reserved.
// (RULE2) Linear law: 0.236 mA per step, zero to 30 mA at top code.
// (RULE3) Office dim code register at 0x0C, code in bits 6:0, bit 7 reserved.
// (RULE4) Drive active level's dim code after dim timeout or when dim enabled.
// (RULE5) Dark maximum code register at 0x0D, code in bits 6:0, bit 7 reserved.
// (RULE6) Square law: codes 1,2,3 give 0.002, 0.007, 0.017 mA; quadratic to full.
// (RULE7) Dark dim code register at 0x0E, bit 7 reserved, code below.
// (RULE8) Dark dim code in bits 6:0, applied on dim timeout or dim enable.
// (RULE9) Both cubic laws use the square-law current mapping.
// (RULE10) Reserved bit 7 reads zero; writing it changes nothing.
module blcur_regs (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    // Register file port
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wr_data,
    output logic      [7:0]  o_rd_data,
    output logic             o_rd_hit,
    // Backlight control state
    input  wire logic        i_dark_sel,
    input  wire logic        i_dim_timeout,
    input  wire logic        i_dim_en,
    input  wire logic [1:0]  i_law,
    // Drive outputs
    output logic      [6:0]  o_drive_code,
    output logic      [14:0] o_drive_ua,
    output logic             o_dimmed
);
    typedef struct packed {
        logic [3:0][6:0] codes;
        logic [7:0]      rd_data;
        logic            rd_hit;
        logic [6:0]      drive_code;
        logic [14:0]     drive_ua;
        logic            dimmed;
    } blcur_state_t;

    blcur_state_t state_q;
    blcur_state_t state_d;
    logic [14:0]  map_ua;

    // Offset decode shared by write and read paths
    function automatic logic [2:0] blcur_decode(input logic [7:0] addr);
        unique case (addr)
            blcur_pkg::REG_OFFICE_MAX: blcur_decode = {1'b1, blcur_pkg::IDX_OFFICE_MAX};
            blcur_pkg::REG_OFFICE_DIM: blcur_decode = {1'b1, blcur_pkg::IDX_OFFICE_DIM};
            blcur_pkg::REG_DARK_MAX:   blcur_decode = {1'b1, blcur_pkg::IDX_DARK_MAX};
            blcur_pkg::REG_DARK_DIM:   blcur_decode = {1'b1, blcur_pkg::IDX_DARK_DIM};
            default:                   blcur_decode = 3'h0;
        endcase
    endfunction

    logic [2:0] dec;
    logic       dim_now;
    logic [1:0] sel_idx;
    logic [6:0] next_code;
    assign dec = blcur_decode(i_addr);

    // (RULE4) Dim on timeout or software request
    // (RULE8) Dark dim code applies the same way
    // Kept out of the state process so the map output forms no loop
    assign dim_now   = i_dim_timeout || i_dim_en;
    assign sel_idx   = {i_dark_sel, dim_now};
    assign next_code = state_q.codes[sel_idx];

    // Map the code being selected so current and code move together
    blcur_law_map u_map (
        .i_code       (next_code),
        .i_law        (i_law),
        .o_current_ua (map_ua)
    );

    // Next state: writes, reads, level and dim selection
    always_comb begin
        state_d = state_q;
        // (RULE1) Register writes; (RULE3) (RULE5) (RULE7) share this path
        // (RULE10) Bit 7 of write data is dropped
        if (i_wr_en && dec[2]) begin
            state_d.codes[dec[1:0]] = i_wr_data[blcur_pkg::CODE_MSB:0];
        end
        // Reads return last stored code; unmapped offsets read zero
        state_d.rd_hit = i_rd_en && dec[2];
        if (i_rd_en) begin
            if (dec[2]) begin
                state_d.rd_data = {1'b0, state_q.codes[dec[1:0]]};
            end else begin
                state_d.rd_data = 8'h00;
            end
        end
        // Code and its current land together at the next edge
        state_d.drive_code = next_code;
        state_d.dimmed     = dim_now;
        state_d.drive_ua   = map_ua;
    end

    // One register stage for all state; reset clears every code
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Every output is a field of the one state register
    assign o_rd_data    = state_q.rd_data;
    assign o_rd_hit     = state_q.rd_hit;
    assign o_drive_code = state_q.drive_code;
    assign o_drive_ua   = state_q.drive_ua;
    assign o_dimmed     = state_q.dimmed;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    // A write to one offset, and a read of it with no write beside
    sequence s_wr(logic [7:0] a);
        i_wr_en && i_addr == a;
    endsequence

    sequence s_rd(logic [7:0] a);
        i_rd_en && !i_wr_en && i_addr == a;
    endsequence

    a_office_max_rb: assert property ( // RULE1
        (s_wr(blcur_pkg::REG_OFFICE_MAX) ##1 s_rd(blcur_pkg::REG_OFFICE_MAX))
        |=> o_rd_data == {1'b0, $past(i_wr_data[6:0], 2)} && o_rd_hit)
        else $error("office max readback wrong");

    a_office_dim_rb: assert property ( // RULE3
        (s_wr(blcur_pkg::REG_OFFICE_DIM) ##1 s_rd(blcur_pkg::REG_OFFICE_DIM))
        |=> o_rd_data == {1'b0, $past(i_wr_data[6:0], 2)})
        else $error("office dim readback wrong");

    a_dark_max_rb: assert property ( // RULE5
        (s_wr(blcur_pkg::REG_DARK_MAX) ##1 s_rd(blcur_pkg::REG_DARK_MAX))
        |=> o_rd_data == {1'b0, $past(i_wr_data[6:0], 2)})
        else $error("dark max readback wrong");

    a_dark_dim_rb: assert property ( // RULE7
        (s_wr(blcur_pkg::REG_DARK_DIM) ##1 s_rd(blcur_pkg::REG_DARK_DIM))
        |=> o_rd_data == {1'b0, $past(i_wr_data[6:0], 2)} && o_rd_hit)
        else $error("dark dim readback wrong");

    // Neither dim source active at the chosen level
    sequence s_bright(logic dark);
        !i_dim_timeout && !i_dim_en && i_dark_sel == dark;
    endsequence

    a_dark_dim_drive: assert property ( // RULE7
        (s_wr(blcur_pkg::REG_DARK_DIM) ##1 (!i_wr_en && i_dark_sel && i_dim_en))
        |=> o_drive_code == $past(i_wr_data[6:0], 2) && o_dimmed)
        else $error("dark dim code not driven");

    a_rsvd_zero: assert property ( // RULE10
        o_rd_data[blcur_pkg::RSVD_BIT] == 1'b0)
        else $error("reserved bit read nonzero");

    // Any mapped read returns the code stored before that edge
    a_read_stored: assert property ( // RULE10
        (i_rd_en && dec[2]) |=>
        o_rd_data == {1'b0, $past(state_q.codes[dec[1:0]])} && o_rd_hit)
        else $error("stored code not read back");

    // Offsets outside the slice read zero and raise no hit
    a_unmapped_read: assert property ( // RULE1
        (i_rd_en && !dec[2]) |=> o_rd_data == 8'h00 && !o_rd_hit)
        else $error("unmapped read not zero");

    // Bit 7 of the write data never reaches the stored code
    a_rsvd_write: assert property ( // RULE10
        (i_wr_en && dec[2]) |=>
        state_q.codes[$past(dec[1:0])] == $past(i_wr_data[blcur_pkg::CODE_MSB:0]))
        else $error("write did not store code bits");

    // Drive selection by level and dim state, one cycle late
    a_dim_select: assert property ( // RULE4
        (i_dim_timeout && !i_dark_sel) |=>
        o_drive_code == $past(state_q.codes[blcur_pkg::IDX_OFFICE_DIM]) && o_dimmed)
        else $error("office dim code not selected");

    a_dark_dim_timeout: assert property ( // RULE8
        (i_dim_timeout && !i_dim_en && i_dark_sel) |=>
        o_drive_code == $past(state_q.codes[blcur_pkg::IDX_DARK_DIM]) && o_dimmed)
        else $error("dark dim code not selected on timeout");

    a_max_select: assert property ( // RULE5
        s_bright(1'b1) |=>
        o_drive_code == $past(state_q.codes[blcur_pkg::IDX_DARK_MAX]) && !o_dimmed)
        else $error("dark max code not selected");

    a_office_max_select: assert property ( // RULE1
        s_bright(1'b0) |=>
        o_drive_code == $past(state_q.codes[blcur_pkg::IDX_OFFICE_MAX]) && !o_dimmed)
        else $error("office max code not selected");

    // Current at the codes whose values are fixed by the laws
    a_linear_map: assert property ( // RULE2
        $past(i_law) == blcur_pkg::LAW_LINEAR |->
        (o_drive_code != blcur_pkg::CODE_TOP || o_drive_ua == blcur_pkg::UA_FULL) &&
        (o_drive_code != 7'h01 || o_drive_ua == blcur_pkg::UA_LIN_1) &&
        (o_drive_code != 7'h00 || o_drive_ua == 15'h0000))
        else $error("linear current wrong");

    a_square_map: assert property ( // RULE6
        $past(i_law) != blcur_pkg::LAW_LINEAR |->
        (o_drive_code != 7'h01 || o_drive_ua == blcur_pkg::UA_SQ_1) &&
        (o_drive_code != 7'h02 || o_drive_ua == blcur_pkg::UA_SQ_2) &&
        (o_drive_code != 7'h03 || o_drive_ua == blcur_pkg::UA_SQ_3) &&
        (o_drive_code != blcur_pkg::CODE_TOP || o_drive_ua == blcur_pkg::UA_FULL))
        else $error("square current wrong");

    a_cubic_map: assert property ( // RULE9
        ($past(i_law) == blcur_pkg::LAW_CUBIC10 || $past(i_law) == blcur_pkg::LAW_CUBIC11) |->
        (o_drive_code != 7'h02 || o_drive_ua == blcur_pkg::UA_SQ_2) &&
        (o_drive_code != 7'h03 || o_drive_ua == blcur_pkg::UA_SQ_3))
        else $error("cubic law current differs from square");
endmodule
`default_nettype wire

/* File: testbench/blcur_host.sv */
`timescale 1ns/100ps
`default_nettype none
module blcur_host (
    // Clock
    input  wire logic       i_sys_clk,
    // Register strobes
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wr_data,
    // Read answer
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_hit
);
    // Bus idle at time zero
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // One strobe from a falling edge; answer taken a cycle later
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] rd, output logic hit);
        @(negedge i_sys_clk);
        o_wr_en = wr;
        o_rd_en = !wr;
        o_addr = a;
        o_wr_data = d;
        @(negedge i_sys_clk);
        rd = i_rd_data;
        hit = i_rd_hit;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        // Stale bus would hide a missed strobe, so park it inverted
        o_addr = ~a;
        o_wr_data = ~d;
    endtask
    // Write, then read the same offset at the very next edge
    task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                              output logic [7:0] rd, output logic hit);
        @(negedge i_sys_clk);
        o_wr_en = 1'b1;
        o_addr = a;
        o_wr_data = d;
        @(negedge i_sys_clk);
        o_wr_en = 1'b0;
        o_rd_en = 1'b1;
        o_wr_data = ~d;
        @(negedge i_sys_clk);
        rd = i_rd_data;
        hit = i_rd_hit;
        o_rd_en = 1'b0;
        o_addr = ~a;
    endtask
endmodule
`default_nettype wire

/* File: testbench/backlight_level_current_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module backlight_level_current_regs_bench;
    logic sys_clk, resetn, wr_en, rd_en, rd_hit, dark_sel, dim_timeout, dim_en, dimmed;
    logic hit, mapped;
    logic [7:0] addr, wr_data, rd_data, got, a, d;
    logic [1:0] law, idx, sel;
    logic [6:0] drive_code;
    logic [14:0] drive_ua;
    logic [6:0] exp_code [4];
    logic [7:0] corner [4] = '{8'h81, 8'h02, 8'h83, 8'hFF};
    logic [31:0] seed;
    int errors, n_compared;
    // Expected current, rounded to the nearest microamp
    function automatic logic [14:0] exp_ua(input logic [6:0] c, input logic [1:0] lw);
        logic [29:0] v;
        v = {23'h0, c};
        if (lw == blcur_pkg::LAW_LINEAR)
            v = (blcur_pkg::MAP_FULL_UA * v + blcur_pkg::MAP_LIN_RND) / blcur_pkg::MAP_LIN_DIV;
        else
            v = (blcur_pkg::MAP_FULL_UA * v * v + blcur_pkg::MAP_SQ_RND) / blcur_pkg::MAP_SQ_DIV;
        // Table currents at the corner codes, independent of the formula
        if (c == blcur_pkg::CODE_TOP) v = 30'(blcur_pkg::UA_FULL);
        if (lw == blcur_pkg::LAW_LINEAR && c == 7'h01) v = 30'(blcur_pkg::UA_LIN_1);
        if (lw != blcur_pkg::LAW_LINEAR && c == 7'h01) v = 30'(blcur_pkg::UA_SQ_1);
        if (lw != blcur_pkg::LAW_LINEAR && c == 7'h02) v = 30'(blcur_pkg::UA_SQ_2);
        if (lw != blcur_pkg::LAW_LINEAR && c == 7'h03) v = 30'(blcur_pkg::UA_SQ_3);
        return v[14:0];
    endfunction
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_drive(input logic [6:0] c, input logic [1:0] lw, input logic dm);
        n_compared++;
        if (drive_code !== c || drive_ua !== exp_ua(c, lw) || dimmed !== dm) begin
            errors++;
            $display("wrong value at %0t: drive %h %h", $time, drive_code, drive_ua);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    blcur_host host (.i_sys_clk(sys_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
        .o_wr_data(wr_data), .i_rd_data(rd_data), .i_rd_hit(rd_hit));
    blcur_regs dut (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_hit(rd_hit),
        .i_dark_sel(dark_sel), .i_dim_timeout(dim_timeout), .i_dim_en(dim_en), .i_law(law),
        .o_drive_code(drive_code), .o_drive_ua(drive_ua), .o_dimmed(dimmed));
    // Clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (4000) @(posedge sys_clk);
        errors++;
        final_report();
    end
    initial begin
        resetn = 1'b0;
        {dark_sel, dim_timeout, dim_en, law} = 5'h00;
        seed = 32'h0000_0026;
        for (int i = 0; i < 4; i++) exp_code[i] = 7'h00;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        // Codes come out of reset at zero
        for (int i = 0; i < 4; i++) begin
            host.access(1'b0, 8'(8'h0B + i), 8'h00, got, hit);
            check8(got, 8'h00);
        end
        // Corners under every law first, then random traffic
        for (int i = 0; i < 64; i++) begin
            seed = xorshift(seed);
            idx = seed[1:0];
            mapped = (i < 16) || (seed[4:2] != 3'h0);
            a = mapped ? 8'h0B + idx : (seed[5] ? 8'h0F : 8'h0A);
            d = (i < 16) ? corner[i % 4] : seed[15:8];
            // Odd passes read back at the edge right after the write
            if (i % 2 == 1) begin
                host.write_read(a, d, got, hit);
            end else begin
                host.access(1'b1, a, d, got, hit);
                host.access(1'b0, a, 8'h00, got, hit);
            end
            if (mapped) exp_code[idx] = d[6:0];
            check8(got, mapped ? {1'b0, exp_code[idx]} : 8'h00);
            check8({7'h00, hit}, {7'h00, mapped});
            sel = (i < 16) ? idx : seed[19:18];
            dark_sel = sel[1];
            dim_timeout = sel[0] & (seed[20] | seed[21]);
            dim_en = sel[0] & ~seed[20];
            law = (i < 16) ? 2'(i / 4) : seed[23:22];
            @(negedge sys_clk);
            check_drive(exp_code[sel], law, sel[0]);
        end
        // Dark level, software dim: a new dark dim code is driven at once
        {dark_sel, dim_timeout, dim_en} = 3'b101;
        host.write_read(8'h0E, 8'hD5, got, hit);
        exp_code[3] = 7'h55;
        check8(got, 8'h55);
        check_drive(exp_code[3], law, 1'b1);
        // Reset in mid-run clears the drive and every code
        @(negedge sys_clk);
        resetn = 1'b0;
        @(negedge sys_clk);
        resetn = 1'b1;
        check_drive(7'h00, law, 1'b0);
        for (int i = 0; i < 4; i++) begin
            host.access(1'b0, 8'(8'h0B + i), 8'h00, got, hit);
            check8(got, 8'h00);
        end
        final_report();
    end
endmodule
`default_nettype wire
